// ---- src/ctb_count_if.sv ----
`timescale 1ns/1ps
interface ctb_count_if;
    import ctb_pkg::*;

    ctb_sel_t    sel;
    logic        tick;
    logic        run;
    logic        load;
    logic [15:0] load_data;
    logic [15:0] count;
    logic        wrap;

    modport tbase (input sel, output tick);
    modport cnt   (input tick, input run, input load, input load_data,
                   output count, output wrap);
    modport ctl   (output sel, output run, output load, output load_data,
                   input count, input wrap);
endinterface : ctb_count_if

// ---- src/ctb_counter.sv ----
`timescale 1ns/1ps
module ctb_counter (
    input  wire logic clk_in,
    input  wire logic rst_n_in,
    ctb_count_if.cnt  cn
);
    import ctb_pkg::*;

    typedef struct packed {
        logic [15:0] count;
        logic        wrap;
    } ctb_cnt_state_t;

    ctb_cnt_state_t st;
    ctb_cnt_state_t next_st;

    always_comb
    begin
        next_st      = st;
        next_st.wrap = 1'b0;
        if (cn.load)
        begin
            next_st.count = cn.load_data;
        end
        else if (cn.run && cn.tick)
        begin
            next_st.count = st.count + 16'h0001;
            next_st.wrap  = (st.count == 16'hffff);
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            st <= '{count: COUNT_RESET, wrap: 1'b0};
        end
        else
        begin
            st <= next_st;
        end
    end

    assign cn.count = st.count;
    assign cn.wrap  = st.wrap;

endmodule : ctb_counter

// ---- src/ctb_pkg.sv ----
package ctb_pkg;

    // Avalon-MM slave geometry: byte addresses, one 32-bit word per register.
    localparam int ADDR_W = 5;
    localparam int DATA_W = 32;

    localparam logic [ADDR_W-1:0] OFS_MODE   = 5'h00;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 5'h04;
    localparam logic [ADDR_W-1:0] OFS_MASK   = 5'h08;
    localparam logic [ADDR_W-1:0] OFS_COUNT  = 5'h0c;

    // Mode register fields.
    localparam int BIT_IDLE_SUSPEND = 7;
    localparam int BIT_WD_ENABLE    = 6;
    localparam int BIT_WD_LOCK      = 5;
    localparam int BIT_UNUSED       = 4;
    localparam int SEL_MSB          = 3;
    localparam int SEL_LSB          = 1;
    localparam int BIT_OVF_IRQ_EN   = 0;

    // Status and mask registers share one layout.
    localparam int BIT_STAT_OVF = 0;

    localparam logic [7:0] MODE_RESET   = 8'h00;
    localparam logic [0:0] STATUS_RESET = 1'h0;
    localparam logic [0:0] MASK_RESET   = 1'h0;
    localparam logic [15:0] COUNT_RESET = 16'h0000;

    // Terminal counts of the prescalers.
    localparam logic [3:0] DIV12_LAST = 4'hb;
    localparam logic [1:0] DIV4_LAST  = 2'h3;
    localparam logic [2:0] DIV8_LAST  = 3'h7;

    typedef enum logic [2:0] {
        SEL_SYS_DIV12 = 3'h0,
        SEL_SYS_DIV4  = 3'h1,
        SEL_TIMER0    = 3'h2,
        SEL_ECI_FALL  = 3'h3,
        SEL_SYS       = 3'h4,
        SEL_EXT_DIV8  = 3'h5,
        SEL_RSVD_6    = 3'h6,
        SEL_RSVD_7    = 3'h7
    } ctb_sel_t;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_ACK  = 2'b10
    } ctb_bus_t;

    // Three-stage synchroniser with agreement filter: returns next stage vector
    // and next filtered level packed as {level, s2, s1, s0}.
    function automatic logic [3:0] ctb_sync_step(input logic [2:0] stages,
                                                  input logic       level,
                                                  input logic       pin);
        logic       lvl;
        lvl = (stages[1] == stages[2]) ? stages[2] : level;
        return {lvl, stages[1:0], pin};
    endfunction : ctb_sync_step

endpackage : ctb_pkg

// ---- src/ctb_timebase.sv ----
`timescale 1ns/1ps
module ctb_timebase (
    input  wire logic clk_in,
    input  wire logic rst_n_in,
    input  wire logic timer0_overflow_in,
    input  wire logic external_count_input_in,
    input  wire logic external_clock_in,
    ctb_count_if.tbase tb
);
    import ctb_pkg::*;

    typedef struct packed {
        logic [2:0] eci_sync;
        logic       eci_level;
        logic [2:0] ext_sync;
        logic       ext_level;
        logic [3:0] div12;
        logic [1:0] div4;
        logic [2:0] ext_div;
        logic       tick;
    } ctb_tb_state_t;

    ctb_tb_state_t st;
    ctb_tb_state_t next_st;

    always_comb
    begin
        logic [3:0] eci_v;
        logic [3:0] ext_v;
        logic       eci_fall;
        logic       ext_rise;
        logic       ext8;
        eci_v    = ctb_sync_step(st.eci_sync, st.eci_level, external_count_input_in);
        ext_v    = ctb_sync_step(st.ext_sync, st.ext_level, external_clock_in);
        eci_fall = st.eci_level & ~eci_v[3];
        ext_rise = ~st.ext_level & ext_v[3];
        ext8     = ext_rise && (st.ext_div == DIV8_LAST);
        next_st           = st;
        next_st.eci_sync  = eci_v[2:0];
        next_st.eci_level = eci_v[3];
        next_st.ext_sync  = ext_v[2:0];
        next_st.ext_level = ext_v[3];
        next_st.div12     = (st.div12 == DIV12_LAST) ? 4'h0 : st.div12 + 4'h1;
        next_st.div4      = st.div4 + 2'h1;
        // The external clock is divided after synchronisation, so every tick is
        // a clean one-cycle pulse of the system clock.
        if (ext_rise)
        begin
            next_st.ext_div = st.ext_div + 3'h1;
        end
        unique case (tb.sel)
            SEL_SYS_DIV12: next_st.tick = (st.div12 == DIV12_LAST);
            SEL_SYS_DIV4:  next_st.tick = (st.div4 == DIV4_LAST);
            SEL_TIMER0:    next_st.tick = timer0_overflow_in;
            SEL_ECI_FALL:  next_st.tick = eci_fall;
            SEL_SYS:       next_st.tick = 1'b1;
            SEL_EXT_DIV8:  next_st.tick = ext8;
            default:       next_st.tick = 1'b0;
        endcase
    end

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign tb.tick = st.tick;

endmodule : ctb_timebase

// ---- src/ctb_top.sv ----
// Functional notes
// - Mode bit 4 reads zero, writes ignored.
// - Select field picks div12, div4, timer0, sysclk.
// - Code 011 counts falling edges of input.
// - Code 101 counts synchronised external clock over eight.
// - Overflow flag raises request only when enabled.
// - Watchdog enabled blocks writes to mode bits other than enable and lock, and to the count; mask writes still land.
// - Watchdog enable turns module 2 into watchdog.
// - Lock keeps watchdog enabled until reset.
// - Idle suspend halts counting during processor idle.
`timescale 1ns/1ps
module ctb_top (
    input  wire logic                          clk_in,
    input  wire logic                          rst_n_in,
    // Avalon-MM slave.
    input  wire logic [ctb_pkg::ADDR_W-1:0]    avs_address_in,
    input  wire logic                          avs_read_in,
    input  wire logic                          avs_write_in,
    input  wire logic [ctb_pkg::DATA_W-1:0]    avs_writedata_in,
    input  wire logic [3:0]                    avs_byteenable_in,
    output logic      [ctb_pkg::DATA_W-1:0]    avs_readdata_out,
    output logic                               avs_waitrequest_out,
    // Count sources and system status.
    input  wire logic                          timer0_overflow_in,
    input  wire logic                          external_count_input_in,
    input  wire logic                          external_clock_in,
    input  wire logic                          cpu_idle_in,
    // Results.
    output logic                               irq_out,
    output logic                               watchdog_enable_out,
    output logic                               counter_overflow_flag_out
);
    import ctb_pkg::*;

    typedef struct packed {
        ctb_bus_t    bus;
        logic [31:0] rdata;
        logic [7:0]  mode;
        logic [0:0]  status;
        logic [0:0]  mask;
        logic        irq;
    } ctb_top_state_t;

    ctb_top_state_t st;
    ctb_top_state_t next_st;

    ctb_count_if cif ();

    ctb_timebase u_timebase (
        .clk_in                  (clk_in),
        .rst_n_in                (rst_n_in),
        .timer0_overflow_in      (timer0_overflow_in),
        .external_count_input_in (external_count_input_in),
        .external_clock_in       (external_clock_in),
        .tb                      (cif.tbase)
    );

    ctb_counter u_counter (
        .clk_in   (clk_in),
        .rst_n_in (rst_n_in),
        .cn       (cif.cnt)
    );

    // Register read data seen by software, by address.
    function automatic logic [31:0] ctb_read_mux(input logic [ADDR_W-1:0] addr,
                                                 input logic [7:0]        mode,
                                                 input logic [0:0]        status,
                                                 input logic [0:0]        mask,
                                                 input logic [15:0]       count);
        logic [31:0] d;
        d = 32'h0000_0000;
        unique case (addr)
            OFS_MODE:
            begin
                d[7:0]          = mode;
                d[BIT_UNUSED]   = 1'b0;
            end
            OFS_STATUS: d[0:0]  = status;
            OFS_MASK:   d[0:0]  = mask;
            OFS_COUNT:  d[15:0] = count;
            default:    d       = 32'h0000_0000;
        endcase
        return d;
    endfunction : ctb_read_mux

    // Applies a software write to the mode register under the watchdog guards.
    function automatic logic [7:0] ctb_mode_write(input logic [7:0] cur,
                                                  input logic [7:0] wr);
        logic [7:0] n;
        n = cur;
        if (!cur[BIT_WD_ENABLE])
        begin
            n = wr;
        end
        else
        begin
            // Only the enable itself may move; the lock may still be set so
            // that software can arm the watchdog permanently.
            n[BIT_WD_ENABLE] = wr[BIT_WD_ENABLE];
            n[BIT_WD_LOCK]   = cur[BIT_WD_LOCK] | wr[BIT_WD_LOCK];
        end
        if (cur[BIT_WD_LOCK])
        begin
            n[BIT_WD_ENABLE] = 1'b1;
            n[BIT_WD_LOCK]   = 1'b1;
        end
        n[BIT_UNUSED] = 1'b0;
        return n;
    endfunction : ctb_mode_write

    logic access_done;
    logic wr_mode;
    logic wr_mask;
    logic wr_count;
    logic rd_status;

    always_comb
    begin
        access_done = (st.bus == BUS_ACK);
        wr_mode     = access_done && avs_write_in && (avs_address_in == OFS_MODE)
                      && avs_byteenable_in[0];
        wr_mask     = access_done && avs_write_in && (avs_address_in == OFS_MASK)
                      && avs_byteenable_in[0];
        // The counter may only be rewritten while the watchdog is off.
        wr_count    = access_done && avs_write_in && (avs_address_in == OFS_COUNT)
                      && !st.mode[BIT_WD_ENABLE];
        rd_status   = access_done && avs_read_in && (avs_address_in == OFS_STATUS);
    end

    // Counter control toward the shared counter.
    always_comb
    begin
        cif.sel       = ctb_sel_t'(st.mode[SEL_MSB:SEL_LSB]);
        // Reserved select codes produce no ticks; software keeps clear of them.
        cif.run       = !(st.mode[BIT_IDLE_SUSPEND] && cpu_idle_in);
        cif.load      = wr_count;
        cif.load_data = st.mode[BIT_WD_ENABLE] ? cif.count : avs_writedata_in[15:0];
        if (wr_count)
        begin
            cif.load_data[7:0]  = avs_byteenable_in[0] ? avs_writedata_in[7:0]
                                                       : cif.count[7:0];
            cif.load_data[15:8] = avs_byteenable_in[1] ? avs_writedata_in[15:8]
                                                       : cif.count[15:8];
        end
    end

    always_comb
    begin
        next_st = st;
        unique case (st.bus)
            BUS_IDLE:
            begin
                if (avs_read_in || avs_write_in)
                begin
                    next_st.bus   = BUS_ACK;
                    next_st.rdata = ctb_read_mux(avs_address_in, st.mode, st.status,
                                                 st.mask, cif.count);
                end
            end
            BUS_ACK:
            begin
                next_st.bus = BUS_IDLE;
            end
            default:
            begin
                next_st.bus = BUS_IDLE;
            end
        endcase

        if (wr_mode)
        begin
            next_st.mode = ctb_mode_write(st.mode, avs_writedata_in[7:0]);
        end
        if (wr_mask)
        begin
            next_st.mask = avs_writedata_in[0:0];
        end

        // Only the bits that were returned are cleared, so an overflow landing
        // between sampling and completion is not lost; a new wrap wins anyway.
        if (rd_status)
        begin
            next_st.status = st.status & ~st.rdata[0:0];
        end
        if (cif.wrap)
        begin
            next_st.status[BIT_STAT_OVF] = 1'b1;
        end

        next_st.irq = next_st.status[BIT_STAT_OVF] && next_st.mask[BIT_STAT_OVF]
                      && next_st.mode[BIT_OVF_IRQ_EN];
    end

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            st <= '{bus: BUS_IDLE, rdata: 32'h0000_0000, mode: MODE_RESET,
                    status: STATUS_RESET, mask: MASK_RESET, irq: 1'b0};
        end
        else
        begin
            st <= next_st;
        end
    end

    assign avs_readdata_out          = st.rdata;
    // The idle code has bit 0 set and the answer code clears it, so waitrequest
    // is the state flop itself with no decode behind it.
    assign avs_waitrequest_out       = st.bus[0];
    assign irq_out                   = st.irq;
    assign watchdog_enable_out       = st.mode[BIT_WD_ENABLE];
    assign counter_overflow_flag_out = st.status[BIT_STAT_OVF];

endmodule : ctb_top

// ---- test/ctb_chk.sv ----
`timescale 1ns/1ps
module ctb_chk (
    input wire logic                       clk_in,
    input wire logic                       rst_n_in,
    input wire logic [ctb_pkg::ADDR_W-1:0] avs_address_in,
    input wire logic                       avs_read_in,
    input wire logic                       avs_write_in,
    input wire logic [ctb_pkg::DATA_W-1:0] avs_readdata_out,
    input wire logic                       avs_waitrequest_out,
    input wire logic                       irq_out,
    input wire logic                       watchdog_enable_out,
    input wire logic                       counter_overflow_flag_out
);
    import ctb_pkg::*;
    logic stat_rd;
    logic unmapped;
    assign stat_rd  = avs_read_in && (avs_address_in == OFS_STATUS);
    assign unmapped = !(avs_address_in inside {OFS_MODE, OFS_STATUS, OFS_MASK, OFS_COUNT});
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    property p_ack;
        (avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out;
    endproperty
    a_ack: assert property (p_ack) else $error("request not answered in one cycle");
    property p_one;
        !avs_waitrequest_out |=> avs_waitrequest_out;
    endproperty
    a_one: assert property (p_one) else $error("waitrequest low too long");
    property p_hold;
        !(avs_read_in || avs_write_in) && avs_waitrequest_out |=> avs_waitrequest_out;
    endproperty
    a_hold: assert property (p_hold) else $error("answer without request");
    property p_unm;
        avs_read_in && avs_waitrequest_out && unmapped |=> avs_readdata_out == '0;
    endproperty
    a_unm: assert property (p_unm) else $error("unmapped read not zero");
    property p_mode;
        avs_read_in && avs_waitrequest_out && avs_address_in == OFS_MODE
            |=> avs_readdata_out[31:8] == '0 && !avs_readdata_out[BIT_UNUSED];
    endproperty
    a_mode: assert property (p_mode) else $error("mode read unused bit set");
    property p_irq;
        irq_out |-> counter_overflow_flag_out;
    endproperty
    a_irq: assert property (p_irq) else $error("irq without overflow flag");
    property p_flag_clr;
        $fell(counter_overflow_flag_out) |-> $past(stat_rd) || $past(stat_rd, 2);
    endproperty
    a_flag_clr: assert property (p_flag_clr) else $error("flag cleared without read");
    property p_wd_fall;
        $fell(watchdog_enable_out) |-> $past(avs_write_in) || $past(avs_write_in, 2);
    endproperty
    a_wd_fall: assert property (p_wd_fall) else $error("watchdog fell without write");
    property p_wd_rise;
        $rose(watchdog_enable_out) |-> $past(avs_write_in) || $past(avs_write_in, 2);
    endproperty
    a_wd_rise: assert property (p_wd_rise) else $error("watchdog rose without write");
    c_rd: cover property (avs_read_in && !avs_waitrequest_out);
    c_irq: cover property ($rose(irq_out));
    c_wd: cover property ($rose(watchdog_enable_out));
endmodule : ctb_chk

bind ctb_top ctb_chk u_chk (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in), .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out), .irq_out(irq_out),
    .watchdog_enable_out(watchdog_enable_out),
    .counter_overflow_flag_out(counter_overflow_flag_out));

// ---- test/testbench.sv ----
`timescale 1ns/1ps
module testbench;
    import ctb_pkg::*;
    logic        clk_in = 0, rst_n_in = 0, avs_read_in = 0, avs_write_in = 0;
    logic [4:0]  avs_address_in = 0;
    logic [31:0] avs_writedata_in = 0, avs_readdata_out;
    logic [3:0]  avs_byteenable_in = 0;
    logic        avs_waitrequest_out, irq_out, watchdog_enable_out, counter_overflow_flag_out;
    logic        timer0_overflow_in = 0, external_count_input_in = 1;
    logic        external_clock_in = 0, cpu_idle_in = 1;
    logic [31:0] exp_q[$];
    int          err_count = 0, checks_done = 0;
    int          ticks[8] = '{8, 24, 6, 4, 96, 2, 0, 0};
    logic [15:0] start;
    logic [16:0] sum;
    logic [7:0]  md;
    logic        ecf;
    always #10 clk_in = ~clk_in;
    ctb_top dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .avs_address_in(avs_address_in),
        .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
        .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(avs_byteenable_in),
        .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
        .timer0_overflow_in(timer0_overflow_in),
        .external_count_input_in(external_count_input_in),
        .external_clock_in(external_clock_in), .cpu_idle_in(cpu_idle_in),
        .irq_out(irq_out), .watchdog_enable_out(watchdog_enable_out),
        .counter_overflow_flag_out(counter_overflow_flag_out));
    task automatic summarize;
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : summarize
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
                       input logic [3:0] be);
        int n;
        n = 0;
        @(posedge clk_in);
        avs_address_in    <= a;
        avs_writedata_in  <= d;
        avs_byteenable_in <= be;
        avs_write_in      <= wr;
        avs_read_in       <= !wr;
        do
        begin
            @(posedge clk_in);
            n++;
        end
        while (avs_waitrequest_out !== 1'b0 && n < 20);
        avs_write_in <= 1'b0;
        avs_read_in  <= 1'b0;
        if (n >= 20)
        begin
            err_count++;
            summarize();
        end
    endtask : bus
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 4'hf);
    endtask : wr
    task automatic rd(input logic [4:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'b0, a, 32'h0, 4'hf);
    endtask : rd
    task automatic chk1(input string nm, input logic e, input logic g);
        checks_done++;
        if (g !== e)
        begin
            err_count++;
            $display("mismatch %s expected %b seen %b", nm, e, g);
        end
    endtask : chk1
    task automatic cmp_rd(input logic [31:0] e);
        checks_done++;
        if (avs_readdata_out !== e)
        begin
            err_count++;
            $display("mismatch readdata expected %h seen %h", e, avs_readdata_out);
        end
    endtask : cmp_rd
    // Read results are matched in issue order; a result with no note is a fault too.
    always @(posedge clk_in)
        if (avs_read_in === 1'b1 && avs_waitrequest_out === 1'b0)
        begin
            if (exp_q.size() == 0)
            begin
                err_count++;
                $display("mismatch readdata expected none seen %h", avs_readdata_out);
            end
            else
                cmp_rd(exp_q.pop_front());
        end
    initial
    begin
        void'($urandom(50891));
        repeat (3) @(posedge clk_in);
        rst_n_in <= 1'b1;
        rd(OFS_MODE, 32'h0);
        rd(OFS_STATUS, 32'h0);
        rd(OFS_MASK, 32'h0);
        rd(OFS_COUNT, 32'h0);
        wr(5'h10, 32'hffffffff);
        rd(5'h10, 32'h0);
        $display("test reset and map done");
        md = 8'($urandom) & 8'h97;
        wr(OFS_MODE, {24'h0, md});
        rd(OFS_MODE, {24'h0, md & 8'h8f});
        bus(1'b1, OFS_MODE, 32'hff, 4'h0);
        rd(OFS_MODE, {24'h0, md & 8'h8f});
        $display("test mode bits done");
        wr(OFS_MASK, 32'h1);
        // The idle gate frames each count window, so the result does not depend on latency.
        // Reserved select codes 11x are never programmed; the mode goes first so
        // the count is suspended before it is loaded.
        for (int c = 0; c < 6; c++)
        begin
            start = 16'hffd0 + 16'($urandom_range(31));
            ecf   = 1'($urandom_range(1));
            wr(OFS_MODE, {24'h0, 8'h80 | 8'(c << 1) | {7'h0, ecf}});
            wr(OFS_COUNT, {16'h0, start});
            for (int i = 0; i < 96; i++)
            begin
                @(posedge clk_in);
                cpu_idle_in             <= 1'b0;
                timer0_overflow_in      <= (i % 16 == 8);
                external_count_input_in <= (i >= 8 && i < 72) ? i[3] : 1'b1;
                external_clock_in       <= (i >= 8 && i < 72) ? i[1] : 1'b0;
            end
            @(posedge clk_in);
            cpu_idle_in        <= 1'b1;
            timer0_overflow_in <= 1'b0;
            repeat (12) @(posedge clk_in);
            sum = {1'b0, start} + 17'(ticks[c]);
            rd(OFS_COUNT, {16'h0, sum[15:0]});
            chk1("flag", sum[16], counter_overflow_flag_out);
            chk1("irq", sum[16] & ecf, irq_out);
            rd(OFS_STATUS, {31'h0, sum[16]});
            repeat (2) @(posedge clk_in);
            chk1("irq_clear", 1'b0, irq_out);
            $display("test select %0d done", c);
        end
        wr(OFS_MODE, 32'hc0);
        repeat (2) @(posedge clk_in);
        chk1("wd_on", 1'b1, watchdog_enable_out);
        wr(OFS_MODE, 32'hcf);
        rd(OFS_MODE, 32'hc0);
        wr(OFS_COUNT, 32'h1234);
        rd(OFS_COUNT, {16'h0, sum[15:0]});
        wr(OFS_MODE, 32'h80);
        rd(OFS_MODE, 32'h80);
        wr(OFS_MODE, 32'hc0);
        wr(OFS_MODE, 32'he0);
        wr(OFS_MODE, 32'h80);
        rd(OFS_MODE, 32'he0);
        chk1("wd_locked", 1'b1, watchdog_enable_out);
        $display("test watchdog done");
        @(posedge clk_in);
        rst_n_in <= 1'b0;
        repeat (3) @(posedge clk_in);
        rst_n_in <= 1'b1;
        rd(OFS_MODE, 32'h0);
        chk1("wd_reset", 1'b0, watchdog_enable_out);
        wr(OFS_MODE, 32'h80);
        rd(OFS_MODE, 32'h80);
        $display("test second reset done");
        summarize();
    end
endmodule : testbench
